// file: src/sph_pkg.sv
// Constants and types for the sanitize, partition and health block
package sph_pkg;
  localparam logic [7:0]  OPC_SANITIZE    = 8'h81;
  localparam logic [7:0]  OPC_PARAM       = 8'hB0;
  localparam logic [7:0]  OPC_FORMAT      = 8'hF7;
  localparam logic [7:0]  FEAT_SET_PARAM  = 8'hF0;
  localparam logic [7:0]  FEAT_SMART_STAT = 8'hDA;
  localparam logic [7:0]  FEAT_SAN_MASK   = 8'h00;
  localparam logic [7:0]  FEAT_SAN_DEF    = 8'h01;
  localparam logic [7:0]  FEAT_SAN_SETDEF = 8'h02;
  localparam logic [31:0] PID_FIRST       = 32'h0001_0000;
  localparam logic [31:0] PID_LAST        = 32'h0001_0007;
  localparam int          NUM_PART        = 4;
  localparam logic [3:0]  DEF_MASK_RST    = 4'h0;
  localparam logic [31:0] LEN_RST         = 32'h0000_0000;
  localparam int          SPARE_PCT       = 4;
  localparam int          HEALTH_PCT      = 95;
  localparam int          MOUNT_MS_4GB    = 2700;
  localparam int          MOUNT_MS_16GB   = 3200;
  localparam int          MOUNT_MS_128GB  = 8700;
  localparam int          CLK_MHZ         = 250;
  localparam int          CYC_PER_MS      = CLK_MHZ * 1000;
  localparam int          SECT_PER_GB     = 2097152;
  localparam logic [2:0]  BIST_UNITS      = 3'h6;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  feature;
    logic [3:0]  mask;
    logic [31:0] id;
    logic [31:0] value;
  } sph_cmd_t;

  typedef struct packed {
    logic        abort;
    logic        smart_fail;
    logic [31:0] spare_total;
    logic [31:0] spare_avail;
  } sph_rsp_t;

  typedef enum logic [2:0] {
    ST_BIST, ST_BIST_FAIL, ST_IDLE, ST_ERASE, ST_FMT, ST_MOUNT
  } sph_state_t;
endpackage

// file: src/sph_core.sv
// Sanitize partitions, spare health, format and power-up test logic
`timescale 1ns/100ps
module sph_core #(
  parameter int unsigned CAPACITY_GB = 4,
  parameter int unsigned SECTORS     = CAPACITY_GB * sph_pkg::SECT_PER_GB,
  parameter int unsigned BLOCKS      = 32768,
  parameter int unsigned MOUNT_CYC   = (CAPACITY_GB >= 128 ?
    sph_pkg::MOUNT_MS_128GB : CAPACITY_GB >= 16 ? sph_pkg::MOUNT_MS_16GB :
    sph_pkg::MOUNT_MS_4GB) * sph_pkg::CYC_PER_MS
) (
  input  wire logic              CLK_IN,          // 250 MHz clock
  input  wire logic              NRST_IN,         // Async reset, low
  input  wire logic              CMD_VALID_IN,    // Command strobe
  input  wire sph_pkg::sph_cmd_t CMD_IN,          // Command fields
  input  wire logic              MEDIA_FAIL_IN,   // Block op failed
  input  wire logic [31:0]       MEDIA_BLK_IN,    // Failing block
  input  wire logic              FMT_DONE_IN,     // Media format done
  input  wire logic              BIST_DONE_IN,    // Unit test finished
  input  wire logic              BIST_OK_IN,      // Unit test passed
  output logic                   CMD_READY_OUT,   // Idle, takes command
  output logic                   RSP_VALID_OUT,   // Response strobe
  output sph_pkg::sph_rsp_t      RSP_OUT,         // Response fields
  output logic                   ERASE_VALID_OUT, // Erase sector strobe
  output logic [31:0]            ERASE_LBA_OUT,   // Sector to erase
  output logic                   REMAP_VALID_OUT, // Remap strobe
  output logic [31:0]            REMAP_BAD_OUT,   // Block marked bad
  output logic [31:0]            REMAP_SPARE_OUT, // Spare taken
  output logic                   FMT_REQ_OUT,     // Format start pulse
  output logic                   BIST_REQ_OUT,    // Unit test start
  output logic [2:0]             BIST_SEL_OUT,    // Unit under test
  output logic                   BIST_FAIL_OUT    // Self test failed
);
  import sph_pkg::*;

  localparam int unsigned SPARE_TOTAL = BLOCKS * SPARE_PCT / 100;
  localparam logic [32:0] SECT_W = 33'(SECTORS);

  // Refuse sizes the sweep, spare pool or mount counter cannot serve
  if (SECTORS == 0 || BLOCKS < 100 || MOUNT_CYC == 0) begin : g_bad_par
    $error("sph_core: unusable parameter values");
  end

  sph_state_t  state_r, state_nxt;
  logic [31:0] start_r [NUM_PART];
  logic [31:0] len_r   [NUM_PART];
  logic [31:0] start_nxt [NUM_PART];
  logic [31:0] len_nxt   [NUM_PART];
  logic [3:0]  defmask_r, defmask_nxt, selmask_r, selmask_nxt;
  logic [31:0] lba_r, lba_nxt, cnt_r, cnt_nxt, used_r, used_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic        wait_r, wait_nxt;
  logic        rsp_valid_nxt, erase_valid_nxt, remap_valid_nxt;
  logic        fmt_req_nxt, bist_req_nxt, bist_fail_nxt;
  sph_rsp_t    rsp_nxt;
  logic [31:0] erase_lba_nxt, remap_bad_nxt, remap_spare_nxt;
  logic [NUM_PART-1:0] hit;
  logic        health_fail, take, spare_left;
  logic [1:0]  pidx;
  logic [32:0] sum_chk;

  // Sector hit test per partition; zero length never hits
  for (genvar i = 0; i < NUM_PART; i++) begin : g_hit
    assign hit[i] = selmask_r[i] && (len_r[i] != LEN_RST) &&
                    (lba_r >= start_r[i]) &&
                    ((lba_r - start_r[i]) < len_r[i]);
  end

  // Health: equal to the limit counts as failed
  assign health_fail = (64'(used_r) * 64'(100)) >=
                       (64'(SPARE_TOTAL) * 64'(HEALTH_PCT));
  assign spare_left  = used_r < SPARE_TOTAL;
  assign take        = CMD_VALID_IN && CMD_READY_OUT;
  assign pidx        = CMD_IN.id[2:1];
  assign sum_chk     = CMD_IN.id[0] ?
                       {1'b0, start_r[pidx]} + {1'b0, CMD_IN.value} :
                       {1'b0, CMD_IN.value} + {1'b0, len_r[pidx]};

  // Next state for sequencing, configuration and outputs
  always_comb begin
    state_nxt       = state_r;
    start_nxt       = start_r;
    len_nxt         = len_r;
    defmask_nxt     = defmask_r;
    selmask_nxt     = selmask_r;
    lba_nxt         = lba_r;
    cnt_nxt         = cnt_r;
    used_nxt        = used_r;
    idx_nxt         = idx_r;
    wait_nxt        = wait_r;
    rsp_valid_nxt   = 1'b0;
    rsp_nxt         = RSP_OUT;
    erase_valid_nxt = 1'b0;
    erase_lba_nxt   = ERASE_LBA_OUT;
    remap_valid_nxt = 1'b0;
    remap_bad_nxt   = REMAP_BAD_OUT;
    remap_spare_nxt = REMAP_SPARE_OUT;
    fmt_req_nxt     = 1'b0;
    bist_req_nxt    = 1'b0;
    bist_fail_nxt   = BIST_FAIL_OUT;
    // Autonomous remap of a failed block to the next spare
    if (MEDIA_FAIL_IN && spare_left) begin
      remap_valid_nxt = 1'b1;
      remap_bad_nxt   = MEDIA_BLK_IN;
      remap_spare_nxt = 32'(BLOCKS - SPARE_TOTAL) + used_r;
      used_nxt        = used_r + 32'h0000_0001;
    end
    unique case (state_r)
      ST_BIST: begin
        if (!wait_r) begin
          bist_req_nxt = 1'b1;
          wait_nxt     = 1'b1;
        end else if (BIST_DONE_IN) begin
          wait_nxt = 1'b0;
          if (!BIST_OK_IN) begin
            bist_fail_nxt = 1'b1;
            state_nxt     = ST_BIST_FAIL;
          end else if (idx_r == BIST_UNITS - 3'h1) begin
            state_nxt = ST_IDLE;
          end else begin
            idx_nxt = idx_r + 3'h1;
          end
        end
      end
      ST_BIST_FAIL: state_nxt = ST_BIST_FAIL;
      ST_IDLE: begin
        if (take) begin
          rsp_nxt = '{abort: 1'b0, smart_fail: 1'b0,
                      spare_total: 32'(SPARE_TOTAL),
                      spare_avail: 32'(SPARE_TOTAL) - used_r};
          rsp_valid_nxt = 1'b1;
          if (CMD_IN.opcode == OPC_PARAM &&
              CMD_IN.feature == FEAT_SET_PARAM) begin
            // Start or length per partition, range checked
            if (CMD_IN.id < PID_FIRST || CMD_IN.id > PID_LAST ||
                sum_chk > SECT_W ||
                (!CMD_IN.id[0] && CMD_IN.value >= SECTORS))
              rsp_nxt.abort = 1'b1;
            else if (CMD_IN.id[0])
              len_nxt[pidx] = CMD_IN.value;
            else
              start_nxt[pidx] = CMD_IN.value;
          end else if (CMD_IN.opcode == OPC_PARAM &&
                       CMD_IN.feature == FEAT_SMART_STAT) begin
            rsp_nxt.smart_fail = health_fail;
          end else if (CMD_IN.opcode == OPC_SANITIZE &&
                       CMD_IN.feature == FEAT_SAN_SETDEF) begin
            defmask_nxt = CMD_IN.mask;
          end else if (CMD_IN.opcode == OPC_SANITIZE &&
                       (CMD_IN.feature == FEAT_SAN_MASK ||
                        CMD_IN.feature == FEAT_SAN_DEF)) begin
            selmask_nxt   = (CMD_IN.feature == FEAT_SAN_DEF) ?
                            defmask_r : CMD_IN.mask;
            lba_nxt       = 32'h0000_0000;
            rsp_valid_nxt = 1'b0;
            state_nxt     = ST_ERASE;
          end else if (CMD_IN.opcode == OPC_FORMAT) begin
            fmt_req_nxt   = 1'b1;
            rsp_valid_nxt = 1'b0;
            state_nxt     = ST_FMT;
          end else begin
            rsp_nxt.abort = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        // Walk all sectors once; erase those in any selected range
        erase_valid_nxt = |hit;
        erase_lba_nxt   = lba_r;
        lba_nxt         = lba_r + 32'h0000_0001;
        if (lba_r == SECTORS - 1) begin
          rsp_valid_nxt = 1'b1;
          rsp_nxt.abort = 1'b0;
          state_nxt     = ST_IDLE;
        end
      end
      ST_FMT: begin
        if (FMT_DONE_IN) begin
          cnt_nxt   = MOUNT_CYC - 1;
          state_nxt = ST_MOUNT;
        end
      end
      ST_MOUNT: begin
        cnt_nxt = cnt_r - 32'h0000_0001;
        if (cnt_r == 32'h0000_0000) begin
          rsp_valid_nxt = 1'b1;
          rsp_nxt.abort = 1'b0;
          state_nxt     = ST_IDLE;
        end
      end
    endcase
  end

  // Register all state and outputs
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_r         <= ST_BIST;
      for (int i = 0; i < NUM_PART; i++) begin
        start_r[i] <= LEN_RST;
        len_r[i]   <= LEN_RST;
      end
      defmask_r       <= DEF_MASK_RST;
      selmask_r       <= 4'h0;
      lba_r           <= 32'h0000_0000;
      cnt_r           <= 32'h0000_0000;
      used_r          <= 32'h0000_0000;
      idx_r           <= 3'h0;
      wait_r          <= 1'b0;
      CMD_READY_OUT   <= 1'b0;
      RSP_VALID_OUT   <= 1'b0;
      RSP_OUT         <= '0;
      ERASE_VALID_OUT <= 1'b0;
      ERASE_LBA_OUT   <= 32'h0000_0000;
      REMAP_VALID_OUT <= 1'b0;
      REMAP_BAD_OUT   <= 32'h0000_0000;
      REMAP_SPARE_OUT <= 32'h0000_0000;
      FMT_REQ_OUT     <= 1'b0;
      BIST_REQ_OUT    <= 1'b0;
      BIST_SEL_OUT    <= 3'h0;
      BIST_FAIL_OUT   <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      start_r         <= start_nxt;
      len_r           <= len_nxt;
      defmask_r       <= defmask_nxt;
      selmask_r       <= selmask_nxt;
      lba_r           <= lba_nxt;
      cnt_r           <= cnt_nxt;
      used_r          <= used_nxt;
      idx_r           <= idx_nxt;
      wait_r          <= wait_nxt;
      CMD_READY_OUT   <= (state_nxt == ST_IDLE);
      RSP_VALID_OUT   <= rsp_valid_nxt;
      RSP_OUT         <= rsp_nxt;
      ERASE_VALID_OUT <= erase_valid_nxt;
      ERASE_LBA_OUT   <= erase_lba_nxt;
      REMAP_VALID_OUT <= remap_valid_nxt;
      REMAP_BAD_OUT   <= remap_bad_nxt;
      REMAP_SPARE_OUT <= remap_spare_nxt;
      FMT_REQ_OUT     <= fmt_req_nxt;
      BIST_REQ_OUT    <= bist_req_nxt;
      BIST_SEL_OUT    <= idx_nxt;
      BIST_FAIL_OUT   <= bist_fail_nxt;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  logic all_zero;
  assign all_zero = (len_r[0] | len_r[1] | len_r[2] | len_r[3]) == LEN_RST;

  sequence s_fmt_take;
    take && CMD_IN.opcode == OPC_FORMAT;
  endsequence
  sequence s_fmt_pulse;
    FMT_REQ_OUT ##1 !FMT_REQ_OUT && !CMD_READY_OUT;
  endsequence

  AST_ZERO_LEN_NO_ERASE: assert property (
    $past(state_r == ST_ERASE && all_zero) |-> !ERASE_VALID_OUT)
    else $error("erase issued with all partition lengths zero");
  AST_UNION_ERASE: assert property (
    state_r == ST_ERASE |-> ##1 ERASE_VALID_OUT == $past(|hit) &&
    ERASE_LBA_OUT == $past(lba_r))
    else $error("erase strobe does not follow partition union");
  AST_BAD_ID_ABORT: assert property (
    take && CMD_IN.opcode == OPC_PARAM && CMD_IN.feature == FEAT_SET_PARAM
    && CMD_IN.id > PID_LAST |-> ##1 RSP_VALID_OUT && RSP_OUT.abort)
    else $error("unknown partition parameter id not aborted");
  AST_DEFAULT_MASK: assert property (
    take && CMD_IN.opcode == OPC_SANITIZE && CMD_IN.feature == FEAT_SAN_DEF
    |-> ##1 selmask_r == $past(defmask_r) && state_r == ST_ERASE)
    else $error("default sanitize did not use default mask");
  AST_REMAP: assert property (
    MEDIA_FAIL_IN && spare_left |-> ##1 REMAP_VALID_OUT &&
    REMAP_BAD_OUT == $past(MEDIA_BLK_IN) && used_r == $past(used_r) + 1)
    else $error("failed block not remapped to spare");
  AST_HEALTH_PASS: assert property (
    take && CMD_IN.opcode == OPC_PARAM && CMD_IN.feature == FEAT_SMART_STAT
    && 64'(used_r) * 100 < 64'(SPARE_TOTAL) * HEALTH_PCT
    |-> ##1 RSP_VALID_OUT && !RSP_OUT.smart_fail)
    else $error("health reported failed below limit");
  AST_HEALTH_FAIL: assert property (
    take && CMD_IN.opcode == OPC_PARAM && CMD_IN.feature == FEAT_SMART_STAT
    && 64'(used_r) * 100 >= 64'(SPARE_TOTAL) * HEALTH_PCT
    |-> ##1 RSP_VALID_OUT && RSP_OUT.smart_fail &&
    RSP_OUT.spare_avail == 32'(SPARE_TOTAL) - $past(used_r))
    else $error("health reported passed at or above limit");
  AST_FORMAT_START: assert property (
    s_fmt_take |-> ##1 s_fmt_pulse)
    else $error("format command did not start media format");
  AST_MOUNT_END: assert property (
    state_r == ST_MOUNT && cnt_r == 0 |-> ##1 RSP_VALID_OUT && CMD_READY_OUT)
    else $error("mount wait did not end in response");
  AST_BIST_ALL: assert property (
    $rose(CMD_READY_OUT) && $past(state_r == ST_BIST) |->
    $past(idx_r) == BIST_UNITS - 3'h1 && !BIST_FAIL_OUT)
    else $error("ready before all self tests passed");
endmodule // sph_core

// file: test/sph_media_model.sv
// Media and self-test responder standing behind the command block
`timescale 1ns/100ps
module sph_media_model (
  input  wire logic       clk_in,        // Device clock
  input  wire logic       nrst_in,       // Async reset, low
  input  wire logic       bist_req_in,   // Unit test start pulse
  input  wire logic [2:0] bist_sel_in,   // Unit under test
  input  wire logic       fmt_req_in,    // Format start pulse
  input  wire logic       slow_in,       // Answer after a long delay
  input  wire logic [2:0] fail_unit_in,  // Unit that reports failure
  output logic            bist_done_out, // Unit test finished
  output logic            bist_ok_out,   // Unit test result
  output logic            fmt_done_out,  // Format complete pulse
  output int              bist_cnt_out   // Unit tests requested
);
  int         bwait;
  int         fwait;
  logic       bpend;
  logic       fpend;
  logic [2:0] sel_r;

  // Answers test and format requests; result line churns when idle
  always @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bist_done_out <= 1'b0;
      bist_ok_out   <= 1'b0;
      fmt_done_out  <= 1'b0;
      bist_cnt_out  <= 0;
      bpend         <= 1'b0;
      fpend         <= 1'b0;
      bwait         <= 0;
      fwait         <= 0;
      sel_r         <= 3'h0;
    end else begin
      bist_done_out <= 1'b0;
      fmt_done_out  <= 1'b0;
      bist_ok_out   <= ~bist_ok_out;
      if (bist_req_in) begin
        bpend        <= 1'b1;
        bwait        <= slow_in ? 6 : 0;
        sel_r        <= bist_sel_in;
        bist_cnt_out <= bist_cnt_out + 1;
      end else if (bpend && bwait == 0) begin
        bist_done_out <= 1'b1;
        bist_ok_out   <= (sel_r != fail_unit_in);
        bpend         <= 1'b0;
      end else if (bpend) begin
        bwait <= bwait - 1;
      end
      if (fmt_req_in) begin
        fpend <= 1'b1;
        fwait <= slow_in ? 6 : 0;
      end else if (fpend && fwait == 0) begin
        fmt_done_out <= 1'b1;
        fpend        <= 1'b0;
      end else if (fpend) begin
        fwait <= fwait - 1;
      end
    end
  end
endmodule // sph_media_model

// file: test/testbench.sv
// Self-checking bench for the sanitize, health and format block
`timescale 1ns/100ps
module testbench;
  import sph_pkg::*;
  logic clk, nrst, cmd_valid, media_fail, slow;
  logic [31:0] media_blk;
  logic [2:0] fail_unit;
  sph_cmd_t cmd;
  logic fmt_done, bist_done, bist_ok, ready, rsp_valid, erase_valid;
  logic remap_valid, fmt_req, bist_req, bist_fail;
  sph_rsp_t rsp_out, rsp;
  logic [31:0] erase_lba, remap_bad, remap_spare, rbad, rspare;
  logic [2:0] bist_sel;
  logic [63:0] era;
  int bist_cnt, cyc, t_take, t_rsp, t_fmt, n_rsp, n_era, n_remap, n_fmt;
  int fails, total_checks, used;

  sph_core #(.SECTORS(64), .MOUNT_CYC(20), .BLOCKS(1000)) u_sph_core (
    .CLK_IN(clk), .NRST_IN(nrst), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd),
    .MEDIA_FAIL_IN(media_fail), .MEDIA_BLK_IN(media_blk),
    .FMT_DONE_IN(fmt_done), .BIST_DONE_IN(bist_done), .BIST_OK_IN(bist_ok),
    .CMD_READY_OUT(ready), .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp_out),
    .ERASE_VALID_OUT(erase_valid), .ERASE_LBA_OUT(erase_lba),
    .REMAP_VALID_OUT(remap_valid), .REMAP_BAD_OUT(remap_bad),
    .REMAP_SPARE_OUT(remap_spare), .FMT_REQ_OUT(fmt_req),
    .BIST_REQ_OUT(bist_req), .BIST_SEL_OUT(bist_sel),
    .BIST_FAIL_OUT(bist_fail));

  sph_media_model u_sph_media_model (
    .clk_in(clk), .nrst_in(nrst), .bist_req_in(bist_req),
    .bist_sel_in(bist_sel), .fmt_req_in(fmt_req), .slow_in(slow),
    .fail_unit_in(fail_unit), .bist_done_out(bist_done),
    .bist_ok_out(bist_ok), .fmt_done_out(fmt_done),
    .bist_cnt_out(bist_cnt));

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Records events seen at each rising edge
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cmd_valid && ready) t_take = cyc;
    if (rsp_valid) begin
      t_rsp = cyc; rsp = rsp_out; n_rsp++;
    end
    if (erase_valid) begin
      era[erase_lba[5:0]] = 1'b1; n_era++;
    end
    if (remap_valid) begin
      rbad = remap_bad; rspare = remap_spare; n_remap++;
    end
    if (fmt_done) t_fmt = cyc;
    if (fmt_req) n_fmt++;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reset for two cycles; a ready that never comes counts when wanted
  task automatic do_reset(input bit want_rdy);
    int k;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    for (k = 0; k < 200 && ready !== 1'b1; k++) @(negedge clk);
    if (want_rdy && ready !== 1'b1) begin
      fails++;
      stop_test;
    end
  endtask

  // One command, held until taken, then waits for its response
  task automatic send(input logic [7:0] op, input logic [7:0] ft,
                      input logic [3:0] m, input logic [31:0] id,
                      input logic [31:0] val);
    int k;
    int n0;
    n0 = n_rsp;
    for (k = 0; k < 200 && ready !== 1'b1; k++) @(negedge clk);
    if (ready !== 1'b1) begin
      fails++;
      stop_test;
    end
    cmd_valid = 1'b1;
    cmd = {op, ft, m, id, val};
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 300 && n_rsp == n0; k++) @(negedge clk);
    if (n_rsp == n0) begin
      fails++;
      stop_test;
    end
  endtask

  task automatic setp(input logic [31:0] idx, input logic [31:0] val);
    send(OPC_PARAM, FEAT_SET_PARAM, 4'h0, PID_FIRST + idx, val);
  endtask

  task automatic sanitize(input logic [7:0] ft, input logic [3:0] m);
    era = 64'h0;
    n_era = 0;
    send(OPC_SANITIZE, ft, m, 32'h0, 32'h0);
  endtask

  task automatic t_boot;
    chk(bist_cnt, 6);
    chk(bist_fail, 1'b0);
    sanitize(FEAT_SAN_MASK, 4'hF);
    chk(n_era, 0);
    chk(t_rsp - t_take, 65);
    $display("test boot done");
  endtask

  task automatic t_partitions;
    int i;
    logic [31:0] v[8] = '{32'h2, 32'h1, 32'h14, 32'h0,
                          32'h4, 32'h6, 32'h7, 32'h5};
    for (i = 0; i < 8; i++) begin
      setp(i, v[i]);
      chk(rsp.abort, 1'b0);
      chk(t_rsp - t_take, 1);
    end
    setp(8, 32'h1);
    chk(rsp.abort, 1'b1);
    setp(7, 32'h3A);
    chk(rsp.abort, 1'b1);
    sanitize(FEAT_SAN_MASK, 4'hF);
    chk(era, 64'h0000_0000_0000_0FF4);
    chk(n_era, 9);
    send(OPC_SANITIZE, FEAT_SAN_SETDEF, 4'h1, 32'h0, 32'h0);
    sanitize(FEAT_SAN_DEF, 4'h0);
    chk(era, 64'h0000_0000_0000_0004);
    setp(0, 32'h0);
    setp(1, 32'h40);
    sanitize(FEAT_SAN_MASK, 4'h1);
    chk(n_era, 64);
    chk(era, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test partitions done");
  endtask

  task automatic inject(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      media_fail = 1'b1;
      media_blk = 32'h100 + used;
      @(negedge clk);
      media_fail = 1'b0;
      @(negedge clk);
      chk(rbad, 32'h100 + used);
      chk(rspare, 960 + used);
      used++;
    end
  endtask

  task automatic health(input logic fail_exp, input int avail);
    send(OPC_PARAM, FEAT_SMART_STAT, 4'h0, 32'h0, 32'h0);
    chk(rsp.smart_fail, fail_exp);
    chk(rsp.spare_total, 40);
    chk(rsp.spare_avail, avail);
  endtask

  task automatic t_health;
    health(1'b0, 40);
    inject(37);
    health(1'b0, 3);
    inject(1);
    health(1'b1, 2);
    inject(2);
    health(1'b1, 0);
    media_fail = 1'b1;
    @(negedge clk);
    media_fail = 1'b0;
    repeat (2) @(negedge clk);
    chk(n_remap, 40);
    $display("test health done");
  endtask

  task automatic t_format;
    send(8'h55, 8'h00, 4'h0, 32'h0, 32'h0);
    chk(rsp.abort, 1'b1);
    slow = 1'b1;
    send(OPC_FORMAT, 8'h00, 4'h0, 32'h0, 32'h0);
    chk(n_fmt, 1);
    chk(rsp.abort, 1'b0);
    chk(t_rsp - t_fmt, 21);
    $display("test format done");
  endtask

  task automatic t_bist_fail;
    fail_unit = 3'h3;
    do_reset(1'b0);
    repeat (40) @(negedge clk);
    chk(bist_fail, 1'b1);
    chk(bist_sel, 3'h3);
    chk(bist_cnt, 4);
    chk(ready, 1'b0);
    $display("test self test failure done");
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0; cmd_valid = 1'b0; cmd = '0; media_fail = 1'b0;
    media_blk = 32'h0; slow = 1'b0; fail_unit = 3'h7; era = 64'h0;
    rsp = '0; rbad = 32'h0; rspare = 32'h0; cyc = 0; t_take = 0;
    t_rsp = 0; t_fmt = 0; n_rsp = 0; n_era = 0; n_remap = 0; n_fmt = 0;
    fails = 0; total_checks = 0; used = 0;
    do_reset(1'b1);
    t_boot;
    t_partitions;
    t_health;
    t_format;
    t_bist_fail;
    stop_test;
  end
endmodule // testbench
